// >>> asrc_map.svh
// constants of the asynchronous sample rate converter core
// assumes inclusion by the core and its package users only
`ifndef ASRC_MAP_SVH
`define ASRC_MAP_SVH
`define ASRC_RAM_DEPTH   512
`define ASRC_OFS_MIN     9'h010
`define ASRC_MUTE_BIT    7
`define ASRC_OFS_MSB     6
`define ASRC_REG_RST     8'h80
`define ASRC_TAPS        9'h040
`define ASRC_RATIO_ONE   9'h040
`define ASRC_RATIO_HYST  9'h002
`define ASRC_DEC_MAX_S   9'h1F0
`define ASRC_DEC_MAX_L   9'h1C0
`define ASRC_WIN_LAST    6'h3F
`define ASRC_ROM_STEP1   27'h0100000
`define ASRC_SCALE_ONE   17'h10000
`define ASRC_GAIN_ONE    16'h8000
`define ASRC_GAIN_STEP   16'h0100
`define ASRC_FAST_SH     2
`define ASRC_SLOW_SH     6
`define ASRC_SETTLE_TOL  29'h0180000
`define ASRC_SETTLE_RUN  4'hF
`endif

// >>> asrc_pkg.sv
// types shared by the sample rate converter core
// assumes nothing beyond a SystemVerilog compiler
package asrc_pkg;
	typedef enum logic [2:0] {FIR_IDLE, FIR_LOAD, FIR_MAC_L, FIR_MAC_R, FIR_PUSH} asrc_fir_t;
	typedef enum logic {SRV_FAST, SRV_SLOW} asrc_srv_t;
endpackage

// >>> asrc_core.sv
// asynchronous stereo sample rate converter core: fifo ram, servo, shared-mac fir
// assumes in_valid and out_tick are synchronous to sys_clk, one pulse per sample
//
// What this block does
// R1: keeps a 512-word sample ram for left and another for right.
// R2: writes at an input-rate counter address that also feeds the servo ramp.
// R3: adds a write offset so the read pointer never reaches the write address.
// R4: write offset is 16 plus the low seven bits of the control register.
// R5: control bit 7 soft-mutes by scaling buffered input toward zero.
// R6: mute and unmute both scale samples before storing, so changes are gradual.
// R7: when decimating, input samples are multiplied by output/input rate ratio.
// R8: servo ramp integer gives ram start, fraction gives rom start.
// R9: when decimating, the rom start fraction is divided by input/output ratio.
// R10: servo goes fast after start or rate change, slow once settled.
// R11: settling flag stands high while the servo is in fast mode.
// R12: optional interrupt pulse when the servo moves from fast to slow.
// R13: software should keep mute set until the servo reaches slow mode.
// R14: fir uses 64 taps, or 64 times input/output ratio when decimating.
// R15: each output period loads start pointers, ram address falls by one per tap.
// R16: rom pointer steps 2^20, or 2^20 divided by the ratio; rollover ends convolution.
// R17: coefficients are interpolated between a reduced stored table.
// R18: left and right are convolved each period on one shared mac.
// R19: ratio comes from counting inputs against outputs, one when output is faster.
// R20: ratio updates only when it moves by more than two, or when it returns to one while decimating.
// R21: decimation is capped at 7.75, or 7 with a longer write offset.
// R22: mute gain ramps one step per input sample and reverses if mute flips.
`timescale 1ns/1ps
`include "asrc_map.svh"

module asrc_core
	import asrc_pkg::*;
(
	input  wire logic        sys_clk,       // 125 MHz system clock
	input  wire logic        rstn,          // asynchronous reset, active low
	input  wire logic        in_valid,      // input sample pair offered
	input  wire logic [23:0] in_left,       // left input sample
	input  wire logic [23:0] in_right,      // right input sample
	output logic             in_ready,      // input sample pair accepted
	input  wire logic        out_tick,      // start of an output sample period
	output logic             out_valid,     // output sample pair offered
	input  wire logic        out_ready,     // sink takes output pair
	output logic [23:0]      out_left,      // left output sample
	output logic [23:0]      out_right,     // right output sample
	input  wire logic        reg_wr,        // write strobe for write_offset_and_mute
	input  wire logic [7:0]  reg_wdata,     // write data
	output logic [7:0]       reg_rdata,     // write_offset_and_mute readback
	input  wire logic        settle_irq_en, // enables the settled interrupt
	output logic             rate_settling, // servo in fast mode
	output logic             settle_irq     // one-cycle pulse on fast to slow
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic signed [15:0] asrc_tab(input logic [4:0] i);
		logic [4:0] k;
		k = (i > 5'h08) ? 5'h10 - i : i;
		case (k)
			5'h00: asrc_tab = 16'h0000;
			5'h01: asrc_tab = 16'h0138;
			5'h02: asrc_tab = 16'h04B0;
			5'h03: asrc_tab = 16'h09E0;
			5'h04: asrc_tab = 16'h1000;
			5'h05: asrc_tab = 16'h1620;
			5'h06: asrc_tab = 16'h1B50;
			5'h07: asrc_tab = 16'h1EC8;
			default: asrc_tab = 16'h2000;
		endcase
	endfunction

	// R17: table interpolation
	function automatic logic signed [15:0] asrc_coef(input logic [25:0] p);
		logic signed [16:0] t0;
		logic signed [16:0] dt;
		logic signed [27:0] w;
		t0 = 17'(asrc_tab({1'b0, p[25:22]}));
		dt = 17'(asrc_tab({1'b0, p[25:22]} + 5'h01)) - t0;
		w  = dt * $signed({1'b0, p[21:12]});
		asrc_coef = 16'(t0 + 17'(w >>> 10));
	endfunction

	// R6: gain applied before storing
	function automatic logic [23:0] asrc_scale(input logic [23:0] x, input logic [15:0] g,
		input logic [16:0] q);
		logic signed [40:0] a;
		logic signed [41:0] b;
		a = $signed(x) * $signed({1'b0, g});
		b = $signed(a[38:15]) * $signed({1'b0, q});
		asrc_scale = b[39:16];
	endfunction

	function automatic logic signed [47:0] asrc_mac(input logic signed [47:0] acc,
		input logic [23:0] x, input logic signed [15:0] c);
		logic signed [39:0] p;
		p = $signed(x) * c;
		asrc_mac = acc + 48'(p);
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0]        ctrl_r;
	logic [23:0]       ram_l [0:`ASRC_RAM_DEPTH-1];
	logic [23:0]       ram_r [0:`ASRC_RAM_DEPTH-1];
	logic [8:0]        wr_cnt_r, wr_addr;
	logic [9:0]        clr_r;
	logic [15:0]       gain_r;
	logic              in_fire, decim;
	logic [8:0]        ratio_r, cap, meas, new_ratio;
	logic [16:0]       recip_r, in_scale;
	logic [9:0]        win_in_r;
	logic [5:0]        win_tick_r;
	logic              win_end, ratio_upd;
	logic [28:0]       pos_r, pred, err, abs_err;
	logic [8:0]        pos_int;
	logic signed [28:0] corr;
	asrc_srv_t         srv_r;
	logic [3:0]        run_r;
	logic              to_slow;
	asrc_fir_t         fir_r;
	logic              pend_r, ratio_chg_r;
	logic [8:0]        rd_r, tap_cnt_r;
	logic [25:0]       rom_r;
	logic [26:0]       rom_step, rom_sum;
	logic [36:0]       frac_prod;
	logic [19:0]       start_frac;
	logic signed [15:0] coef;
	logic signed [47:0] acc_l_r, acc_r_r;
	logic              push, pop, buf_full, skid_v_r;
	logic [23:0]       skid_l_r, skid_r_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// control register and input fifo
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r    <= `ASRC_REG_RST;
			reg_rdata <= `ASRC_REG_RST;
			in_ready  <= 1'b0;
		end else begin
			if (reg_wr)
				ctrl_r <= reg_wdata;
			reg_rdata <= ctrl_r;
			in_ready  <= clr_r[9];
		end
	end

	// ram clear sweep after reset, so the first convolutions read zeros and not junk
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			clr_r <= 10'h000;
		else if (!clr_r[9])
			clr_r <= clr_r + 10'h001;
	end

	assign in_fire = in_valid & in_ready;
	// R3: write stays ahead of the read start
	// R4: offset is minimum plus programmed count
	assign wr_addr = wr_cnt_r + `ASRC_OFS_MIN + {2'b00, ctrl_r[`ASRC_OFS_MSB:0]};
	assign decim = ratio_r != `ASRC_RATIO_ONE;
	// R7: attenuate by out/in when decimating
	assign in_scale = decim ? recip_r : `ASRC_SCALE_ONE;

	// R2: input-rate write counter
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			wr_cnt_r <= 9'h000;
		else if (in_fire)
			wr_cnt_r <= wr_cnt_r + 9'h001;
	end

	// R5: ramp toward zero while muted
	// R22: one step per sample, reverses freely
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			gain_r <= 16'h0000;
		else if (in_fire) begin
			if (ctrl_r[`ASRC_MUTE_BIT] && gain_r != 16'h0000)
				gain_r <= gain_r - `ASRC_GAIN_STEP;
			else if (!ctrl_r[`ASRC_MUTE_BIT] && gain_r != `ASRC_GAIN_ONE)
				gain_r <= gain_r + `ASRC_GAIN_STEP;
		end
	end

	// R1: sample storage, swept to zero once after reset
	always_ff @(posedge sys_clk) begin
		if (!clr_r[9]) begin
			ram_l[clr_r[8:0]] <= 24'h000000;
			ram_r[clr_r[8:0]] <= 24'h000000;
		end else if (in_fire) begin
			ram_l[wr_addr] <= asrc_scale(in_left, gain_r, in_scale);
			ram_r[wr_addr] <= asrc_scale(in_right, gain_r, in_scale);
		end
	end

	// ----------------------------------------
	// sample rate ratio
	// ----------------------------------------
	// R21: a longer offset leaves less room for taps
	assign cap  = (ctrl_r[`ASRC_OFS_MSB:0] == 7'h00) ? `ASRC_DEC_MAX_S : `ASRC_DEC_MAX_L;
	assign meas = (win_in_r > {1'b0, cap}) ? cap : win_in_r[8:0];
	// R19: ratio held at one unless input is faster
	assign new_ratio = (meas <= `ASRC_RATIO_ONE) ? `ASRC_RATIO_ONE : meas;
	assign win_end = out_tick && win_tick_r == `ASRC_WIN_LAST;
	// R20: hysteresis, except a return to one while decimating
	assign ratio_upd = win_end && ((new_ratio == `ASRC_RATIO_ONE && decim)
		|| (new_ratio > ratio_r && new_ratio - ratio_r > `ASRC_RATIO_HYST)
		|| (ratio_r > new_ratio && ratio_r - new_ratio > `ASRC_RATIO_HYST));

	// inputs counted over 64 output periods give in/out in 1/64 steps
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			win_in_r   <= 10'h000;
			win_tick_r <= 6'h00;
		end else begin
			if (out_tick)
				win_tick_r <= win_tick_r + 6'h01;
			if (win_end)
				win_in_r <= {9'h000, in_fire};
			else if (in_fire && win_in_r != 10'h3FF)
				win_in_r <= win_in_r + 10'h001;
		end
	end

	// divide only on update; the reciprocal is reused for data, rom step and start
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ratio_r <= `ASRC_RATIO_ONE;
			recip_r <= `ASRC_SCALE_ONE;
		end else if (ratio_upd) begin
			ratio_r <= new_ratio;
			recip_r <= 17'(23'h400000 / {14'h0000, new_ratio});
		end
	end

	// ----------------------------------------
	// digital servo loop
	// ----------------------------------------
	assign pred    = pos_r + {6'h00, ratio_r, 14'h0000};
	assign err     = {wr_cnt_r, 20'h00000} - pred;
	assign abs_err = err[28] ? 29'h0 - err : err;
	assign corr    = (srv_r == SRV_FAST) ? $signed(err) >>> `ASRC_FAST_SH
		: $signed(err) >>> `ASRC_SLOW_SH;
	assign to_slow = out_tick && !ratio_upd && srv_r == SRV_FAST
		&& abs_err < `ASRC_SETTLE_TOL && run_r == `ASRC_SETTLE_RUN;
	assign pos_int = pos_r[28:20];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			pos_r <= 29'h0000000;
		else if (out_tick)
			pos_r <= pred + $unsigned(corr);
	end

	// R10: fast after reset or rate change
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			srv_r <= SRV_FAST;
			run_r <= 4'h0;
		end else if (out_tick) begin
			if (ratio_upd) begin
				srv_r <= SRV_FAST;
				run_r <= 4'h0;
			end else if (to_slow)
				srv_r <= SRV_SLOW;
			else if (srv_r == SRV_FAST)
				run_r <= (abs_err < `ASRC_SETTLE_TOL) ? run_r + 4'h1 : 4'h0;
		end
	end

	// R11: settling flag
	// R12: gated settle pulse
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rate_settling <= 1'b1;
			settle_irq    <= 1'b0;
		end else begin
			rate_settling <= srv_r == SRV_FAST;
			settle_irq    <= to_slow & settle_irq_en;
		end
	end

	// ----------------------------------------
	// polyphase fir
	// ----------------------------------------
	// R9: rom start shrinks with the ratio
	assign frac_prod  = pos_r[19:0] * recip_r;
	// R8: fraction of the ramp picks the phase
	assign start_frac = decim ? frac_prod[35:16] : pos_r[19:0];
	// R16: step per tap
	assign rom_step   = decim ? {6'h00, recip_r, 4'h0} : `ASRC_ROM_STEP1;
	assign rom_sum    = {1'b0, rom_r} + rom_step;
	assign coef       = asrc_coef(rom_r);
	assign buf_full   = out_valid & skid_v_r;
	assign push       = fir_r == FIR_PUSH && !buf_full;
	assign pop        = out_valid & out_ready;

	// a tick during a convolution is kept, set wins over the clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend_r      <= 1'b0;
			ratio_chg_r <= 1'b0;
		end else begin
			pend_r      <= out_tick | (pend_r & fir_r != FIR_LOAD);
			ratio_chg_r <= ratio_upd | (ratio_chg_r & fir_r != FIR_LOAD);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fir_r     <= FIR_IDLE;
			rd_r      <= 9'h000;
			rom_r     <= 26'h0000000;
			tap_cnt_r <= 9'h000;
			acc_l_r   <= 48'sh0;
			acc_r_r   <= 48'sh0;
		end else begin
			case (fir_r)
				FIR_IDLE: begin
					if (pend_r)
						fir_r <= FIR_LOAD;
				end
				// R15: load start pointers
				FIR_LOAD: begin
					rd_r      <= pos_int;
					rom_r     <= {6'h00, start_frac};
					tap_cnt_r <= 9'h000;
					acc_l_r   <= 48'sh0;
					acc_r_r   <= 48'sh0;
					fir_r     <= FIR_MAC_L;
				end
				// R18: one mac, left then right per tap
				FIR_MAC_L: begin
					acc_l_r <= asrc_mac(acc_l_r, ram_l[rd_r], coef);
					fir_r   <= FIR_MAC_R;
				end
				// R14: tap count follows from the rom step
				FIR_MAC_R: begin
					acc_r_r   <= asrc_mac(acc_r_r, ram_r[rd_r], coef);
					rd_r      <= rd_r - 9'h001;
					rom_r     <= rom_sum[25:0];
					tap_cnt_r <= tap_cnt_r + 9'h001;
					fir_r     <= rom_sum[26] ? FIR_PUSH : FIR_MAC_L;
				end
				FIR_PUSH: begin
					if (!buf_full)
						fir_r <= FIR_IDLE;
				end
				default: fir_r <= FIR_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// two-entry output buffer
	// ----------------------------------------
	// the head doubles as the output register; the skid entry absorbs one stall
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			out_left  <= 24'h000000;
			out_right <= 24'h000000;
			skid_v_r  <= 1'b0;
			skid_l_r  <= 24'h000000;
			skid_r_r  <= 24'h000000;
		end else if (pop && skid_v_r) begin
			out_left  <= skid_l_r;
			out_right <= skid_r_r;
			skid_v_r  <= 1'b0;
		end else if (push && (pop || !out_valid)) begin
			out_valid <= 1'b1;
			out_left  <= acc_l_r[41:18];
			out_right <= acc_r_r[41:18];
		end else if (push) begin
			skid_v_r <= 1'b1;
			skid_l_r <= acc_l_r[41:18];
			skid_r_r <= acc_r_r[41:18];
		end else if (pop)
			out_valid <= 1'b0;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence seq_tap_pair;
		(fir_r == FIR_MAC_L) ##1 (fir_r == FIR_MAC_R);
	endsequence
	sequence seq_load;
		(fir_r == FIR_LOAD) ##1 (fir_r == FIR_MAC_L && rd_r == $past(pos_int));
	endsequence

	chk_wr_count_step: assert property (in_fire |=> wr_cnt_r == $past(wr_cnt_r) + 9'h001) // R2
		else $error("write counter did not advance");
	chk_write_offset: assert property (wr_addr - wr_cnt_r >= `ASRC_OFS_MIN // R4
		&& wr_addr - wr_cnt_r == `ASRC_OFS_MIN + {2'b00, ctrl_r[6:0]})
		else $error("write offset wrong");
	chk_mute_ramp: assert property (in_fire && ctrl_r[7] && gain_r != 16'h0000 // R5
		|=> gain_r == $past(gain_r) - `ASRC_GAIN_STEP)
		else $error("mute gain did not fall");
	chk_fir_load: assert property ((fir_r == FIR_LOAD) |-> seq_load) // R15
		else $error("start pointer not loaded");
	chk_mac_share: assert property ((fir_r == FIR_MAC_L) |-> seq_tap_pair) // R18
		else $error("right tap did not follow left tap");
	chk_tap_count: assert property (fir_r == FIR_PUSH && !ratio_chg_r && !decim // R14
		|-> tap_cnt_r == `ASRC_TAPS)
		else $error("unity ratio did not give 64 taps");
	chk_ratio_cap: assert property (ratio_r >= `ASRC_RATIO_ONE && ratio_r <= `ASRC_DEC_MAX_S) // R21
		else $error("ratio out of range");
	chk_rate_fast: assert property (ratio_upd |=> srv_r == SRV_FAST ##1 rate_settling) // R10
		else $error("rate change did not force fast mode");
	chk_settle_flag: assert property ($fell(rate_settling) |-> $past(srv_r, 2) == SRV_FAST // R11
		&& $past(srv_r) == SRV_SLOW)
		else $error("settling flag out of step");
	chk_settle_irq: assert property (settle_irq |-> $past(to_slow) && $past(settle_irq_en) // R12
		##1 !settle_irq)
		else $error("settle pulse wrong");

endmodule

// >>> asrc_partner.sv
// upstream sample source, output tick source and downstream sink for the core
// assumes sys_clk free running; outputs change on the falling edge except got_cnt, got_left and got_right
`timescale 1ns/1ps

module asrc_partner (
	input  wire logic        sys_clk,   // system clock
	input  wire logic        rstn,      // reset, active low
	input  wire logic [15:0] in_per,    // input period in cycles, 0 stops
	input  wire logic [15:0] out_per,   // output period in cycles, 0 stops
	input  wire logic        stall,     // sink refuses while high
	input  wire logic [23:0] smp_left,  // left value to send
	input  wire logic [23:0] smp_right, // right value to send
	output logic             in_valid,  // pair offered
	output logic [23:0]      in_left,   // left sample
	output logic [23:0]      in_right,  // right sample
	input  wire logic        in_ready,  // core accepts
	output logic             out_tick,  // output period start
	input  wire logic        out_valid, // core offers pair
	output logic             out_ready, // sink takes pair
	input  wire logic [23:0] out_left,  // left result
	input  wire logic [23:0] out_right, // right result
	output int               tick_cnt,  // ticks issued
	output int               got_cnt,   // pairs taken
	output logic [23:0]      got_left,  // last left taken
	output logic [23:0]      got_right  // last right taken
);
	int   in_c;
	int   out_c;
	logic in_take;

	initial begin
		{in_valid, out_tick, out_ready, in_take} = 4'h0;
		{in_left, in_right} = {24'h5A5A5A, 24'hA5A5A5};
		in_c = 0;
		out_c = 0;
		tick_cnt = 0;
		got_cnt = 0;
		{got_left, got_right} = {24'h000000, 24'h000000};
	end

	always @(posedge sys_clk) begin
		in_take <= in_valid & in_ready;
		if (out_valid && out_ready) begin
			got_cnt   <= got_cnt + 1;
			got_left  <= out_left;
			got_right <= out_right;
		end
	end

	// one pair per input period, held until taken
	always @(negedge sys_clk) begin
		out_ready <= !stall;
		out_tick  <= 1'b0;
		if (in_take) begin
			in_valid <= 1'b0;
			in_left  <= ~in_left;
			in_right <= ~in_right;
		end
		if (rstn && in_per != 0) begin
			in_c <= (in_c + 1 >= in_per) ? 0 : in_c + 1;
			if (in_c + 1 >= in_per) begin
				in_valid <= 1'b1;
				in_left  <= smp_left;
				in_right <= smp_right;
			end
		end
		if (rstn && out_per != 0) begin
			out_c <= (out_c + 1 >= out_per) ? 0 : out_c + 1;
			if (out_c + 1 >= out_per) begin
				out_tick <= 1'b1;
				tick_cnt <= tick_cnt + 1;
			end
		end
	end
endmodule

// >>> asrc_core_tb.sv
// self-checking bench for the sample rate converter core
// assumes asrc_core and asrc_partner; inputs change on the falling edge
`timescale 1ns/1ps

module asrc_core_tb;
	import asrc_pkg::*;
	localparam int CEIL = 100000;
	logic        sys_clk, rstn, in_valid, in_ready, out_tick, out_valid, out_ready;
	logic        reg_wr, settle_irq_en, rate_settling, settle_irq, stall;
	logic [23:0] in_left, in_right, out_left, out_right, sl, sr, got_left, got_right, e, h;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [15:0] in_per, out_per;
	int          tick_cnt, got_cnt, err_count, n_tests, cyc, irq_n, n;

	asrc_core uut (.sys_clk(sys_clk), .rstn(rstn), .in_valid(in_valid), .in_left(in_left),
		.in_right(in_right), .in_ready(in_ready), .out_tick(out_tick), .out_valid(out_valid),
		.out_ready(out_ready), .out_left(out_left), .out_right(out_right), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .settle_irq_en(settle_irq_en),
		.rate_settling(rate_settling), .settle_irq(settle_irq));

	asrc_partner far (.sys_clk(sys_clk), .rstn(rstn), .in_per(in_per), .out_per(out_per),
		.stall(stall), .smp_left(sl), .smp_right(sr), .in_valid(in_valid), .in_left(in_left),
		.in_right(in_right), .in_ready(in_ready), .out_tick(out_tick), .out_valid(out_valid),
		.out_ready(out_ready), .out_left(out_left), .out_right(out_right),
		.tick_cnt(tick_cnt), .got_cnt(got_cnt), .got_left(got_left), .got_right(got_right));

	// ------------------------------------------------------------
	// clock, timeout and helpers
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (settle_irq === 1'b1)
			irq_n <= irq_n + 1;
		if (cyc == CEIL) begin
			err_count = err_count + 1;
			$display("mismatch at %0t: run too long", $time);
			test_done();
		end
	end

	task automatic test_done;
		$display("checks %0d, errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic ok(input logic c, input string msg);
		n_tests = n_tests + 1;
		if (c !== 1'b1) begin
			err_count = err_count + 1;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	// readback shows the value one edge after the write edge
	task automatic wreg(input logic [7:0] v);
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		repeat (2) @(negedge sys_clk);
		ok(reg_rdata === v, "register readback");
	endtask

	// cycles from a tick to out_valid, sink ready and buffer empty
	task automatic latency(input int lo, input int hi);
		n = 0;
		while (out_tick !== 1'b1 && n < 600) begin
			@(negedge sys_clk);
			n = n + 1;
		end
		n = 0;
		while (out_valid !== 1'b1 && n < 600) begin
			@(negedge sys_clk);
			n = n + 1;
		end
		ok(n >= lo && n <= hi, "output latency");
	endtask

	task automatic wait_settle(input logic lvl, input int lim);
		n = 0;
		while (rate_settling !== lvl && n < lim) begin
			@(negedge sys_clk);
			n = n + 1;
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		cyc = 0;
		irq_n = 0;
		err_count = 0;
		n_tests = 0;
		n = 0;
		{rstn, reg_wr, stall, settle_irq_en} = 4'h1;
		rstn = 1'b0;
		{reg_wdata, in_per, out_per} = {8'h00, 16'h0000, 16'h0000};
		{sl, sr} = {24'h100000, 24'hF00000};
		repeat (16) @(negedge sys_clk);
		ok(in_ready === 1'b0 && out_valid === 1'b0 && settle_irq === 1'b0, "reset outputs");
		ok(reg_rdata === 8'h80, "register reset value");
		ok(rate_settling === 1'b1, "fast mode at reset");
		rstn = 1'b1;
		// ready only once the ram clear sweep is over
		repeat (520) @(negedge sys_clk);
		ok(in_ready === 1'b1, "ready after reset");
		wreg(8'h00);
		wreg(8'h7F);
		wreg(8'h55);
		wreg(8'hAA);
		reg_wdata = 8'h12;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wdata = 8'h80;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		repeat (2) @(negedge sys_clk);
		ok(reg_rdata === 8'h80, "back to back write");
		// output not slower than input: ratio one, 64 taps
		in_per = 16'd150;
		out_per = 16'd140;
		latency(128, 136);
		repeat (1500) @(negedge sys_clk);
		ok(got_cnt > 0 && got_left === 24'h000000 && got_right === 24'h000000, "muted out");
		wait_settle(1'b0, 25000);
		ok(rate_settling === 1'b0, "servo reached slow mode");
		repeat (3) @(negedge sys_clk);
		ok(irq_n == 1, "one settle interrupt");
		wreg(8'h00);
		repeat (4500) @(negedge sys_clk);
		e = got_left;
		repeat (21000) @(negedge sys_clk);
		ok($signed(e) > 0 && $signed(e) < $signed(got_left), "gradual unmute");
		ok($signed(got_right) < 0, "right channel converted");
		stall = 1'b1;
		repeat (280) @(negedge sys_clk);
		ok(out_valid === 1'b1, "result held while stalled");
		h = out_left;
		repeat (100) @(negedge sys_clk);
		ok(out_left === h && out_valid === 1'b1, "held result stable");
		out_per = 16'd0;
		stall = 1'b0;
		repeat (600) @(negedge sys_clk);
		ok(got_cnt == tick_cnt, "no result lost across stall");
		// input twice the output rate: ratio two, 128 taps
		in_per = 16'd140;
		out_per = 16'd280;
		wait_settle(1'b1, 25000);
		ok(rate_settling === 1'b1, "rate change re-enters fast mode");
		// the first window may mix both rates; the next clean window settles the ratio
		repeat (18000) @(negedge sys_clk);
		latency(256, 264);
		test_done();
	end
endmodule
